//--- design/sbio_consts.svh
`ifndef SBIO_CONSTS_SVH
`define SBIO_CONSTS_SVH

// Clock period of SYS_CLK in ns (40 MHz)
`define SBIO_CLK_PERIOD_NS 25

// Data port timing in ns
`define SBIO_SETUP_NS   500
`define SBIO_HOLD_NS    500
`define SBIO_STROBE_NS  5500
`define SBIO_SAMPLE_NS  12000
`define SBIO_TICK_NS    8000
`define SBIO_BLOCK_NS   256000

// Derived cycle counts
`define SBIO_SETUP_CYC  (`SBIO_SETUP_NS / `SBIO_CLK_PERIOD_NS)
`define SBIO_HOLD_CYC   (`SBIO_HOLD_NS / `SBIO_CLK_PERIOD_NS)
`define SBIO_STROBE_CYC (`SBIO_STROBE_NS / `SBIO_CLK_PERIOD_NS)
`define SBIO_SAMPLE_CYC (`SBIO_SAMPLE_NS / `SBIO_CLK_PERIOD_NS)
`define SBIO_TICK_CYC   (`SBIO_TICK_NS / `SBIO_CLK_PERIOD_NS)
`define SBIO_BLOCK_CYC  (`SBIO_BLOCK_NS / `SBIO_CLK_PERIOD_NS)

// Filter ticks for time code 0 (128 us at 8 us a tick)
`define SBIO_FILT_BASE_TICKS 11'h010
// Time code selecting cycle-based filtering
`define SBIO_CYCLE_CODE      3'h7
// Output register value after reset or address deletion
`define SBIO_OUT_RESET       4'hF
// Mask that inverts every input channel
`define SBIO_INV_ALL         4'hF

`endif

//--- design/sbio_pkg.sv
package sbio_pkg;

  // Commands handed over by the telegram logic
  typedef enum logic [1:0] {
    SBIO_CMD_NONE     = 2'b00,
    SBIO_CMD_PARAM    = 2'b01,  // param_write_code
    SBIO_CMD_EXCHANGE = 2'b10,  // io_exchange_code
    SBIO_CMD_DELETE   = 2'b11   // delete address
  } sbio_cmd_code_type;

  // Output sequence states
  typedef enum logic [1:0] {
    SBIO_ST_IDLE   = 2'b00,
    SBIO_ST_SETUP  = 2'b01,
    SBIO_ST_STROBE = 2'b10,
    SBIO_ST_WAIT   = 2'b11
  } sbio_state_type;

  // One command with its output data
  typedef struct packed {
    logic              valid;
    sbio_cmd_code_type code;
    logic [3:0]        data;
  } sbio_cmd_type;

  // Static configuration
  typedef struct packed {
    logic       invert_all;
    logic [3:0] input_invert_mask;
    logic [3:0] input_filter_mask;
    logic [2:0] filter_time_code;
    logic       pin_filter_control_flag;
    logic       mux_data;
    logic       param_mux;
  } sbio_cfg_type;

  // Answer to an exchange
  typedef struct packed {
    logic       valid;
    logic [3:0] data;
  } sbio_resp_type;

endpackage : sbio_pkg

//--- design/sbio_debounce.sv
`include "sbio_consts.svh"

// One input channel debounce filter, time or cycle based
module sbio_debounce (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        arst_n,
  // Conditioned input and timing
  input  wire logic        raw,
  input  wire logic        tick,
  input  wire logic [10:0] limit,
  // Cycle mode control
  input  wire logic        cycle_mode,
  input  wire logic        sample_evt,
  // Filtered level
  output logic             filt
);

  logic        prev_raw;    // Raw level one cycle ago
  logic        last_sample; // Level of previous exchange sample
  logic [10:0] cnt;         // Stable ticks seen so far

  // Change detector for the raw level
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      prev_raw <= 1'b0;
    end else begin
      prev_raw <= raw;
    end
  end

  // Stability timer, restarted by any change
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt <= 11'h000; // R18
    end else if (cycle_mode || raw != prev_raw || raw == filt) begin
      cnt <= 11'h000;
    end else if (tick) begin
      // First tick is partial, so the wait lands a little short
      cnt <= (cnt == limit - 11'h001) ? 11'h000 : cnt + 11'h001;
    end
  end

  // Filter output: passes a level only once it held long enough
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      filt        <= 1'b0; // R18
      last_sample <= 1'b0;
    end else if (cycle_mode) begin
      if (sample_evt) begin
        last_sample <= raw;
        // Two equal consecutive samples validate
        if (raw == last_sample) begin
          filt <= raw; // R15
        end
      end
    end else if (tick && raw == prev_raw && raw != filt
                 && cnt == limit - 11'h001) begin
      filt <= raw; // R13
    end
  end

endmodule : sbio_debounce

//--- design/sbio_data_port.sv
// Overview of operation
// R1 - Four open-drain outputs, four high-impedance inputs
// R2 - Latch master output data, drive onto pins
// R3 - Low outputs valid 0.5 us before strobe
// R4 - Multiplex option floats drivers around strobe fall
// R5 - Each update gives strobe pulse 5 to 6 us
// R6 - Sample inputs 11 to 13.5 us after write
// R7 - Reset or delete: 0xF, float, strobe
// R8 - Disable flag blocks port and exchange answers
// R9 - Parameter write clears the disable flag
// R10 - Master sends parameter write before first exchange
// R11 - Joint inversion inverts all, ignores mask
// R12 - Otherwise per-channel inversion by mask bit
// R13 - Filter passes level after stable filter time
// R14 - Time code 0..6 scales 128 us; 7 cycle
// R15 - Cycle mode: two equal exchange samples validate
// R16 - Cycle mode blocks sampling 256 us after sample
// R17 - Per-channel filter enable mask
// R18 - Filters start at zero, timers cleared
// R19 - Pin filter option: pin one selects raw
// R20 - Pin filter option keeps pin one unmultiplexed
// R21 - Inversion and filtering combine freely
// R22 - First parameter write enables output driving
// R23 - Invert before filtering, timebase from clock
`include "sbio_consts.svh"

module sbio_data_port
  import sbio_pkg::*;
#(
  // Sampling block time after a cycle-mode sample
  parameter int unsigned BLOCK_CYCLES = `SBIO_BLOCK_CYC
) (
  // Clock and reset
  input  wire logic          SYS_CLK,
  input  wire logic          ARST_N,
  // Commands from telegram logic
  input  wire sbio_cmd_type  CMD,
  // Configuration
  input  wire sbio_cfg_type  CFG,
  input  wire logic          PARAM_PIN_ONE,
  // Data input pins
  input  wire logic [3:0]    DATA_IN_PINS,
  // Data output pins, open drain
  input  wire logic [3:0]    DATA_OUT_PINS_I,
  output logic [3:0]         DATA_OUT_PINS_O,
  output logic [3:0]         DATA_OUT_PINS_OE,
  // Data strobe, low during pulse
  output logic               DATA_STROBE_N,
  // Exchange answer
  output sbio_resp_type      RESP,
  // Status
  output logic               EXCHANGE_DISABLED,
  output logic               BUSY,
  output logic               PARAM_PIN_ONE_MUX_EN,
  output logic [3:0]         DATA_OUT_READBACK
);

  // Cycle counts; sequence ones measured from the output write, tick one free-running, block one counted down from each cycle-mode sample
  localparam logic [8:0] SETUP_END  = 9'(`SBIO_SETUP_CYC);
  localparam logic [8:0] HIZ_END    = 9'(`SBIO_SETUP_CYC + `SBIO_HOLD_CYC);
  localparam logic [8:0] STROBE_END = 9'(`SBIO_SETUP_CYC + `SBIO_STROBE_CYC);
  localparam logic [8:0] SAMPLE_AT  = 9'(`SBIO_SAMPLE_CYC);
  localparam logic [8:0] TICK_LAST  = 9'(`SBIO_TICK_CYC - 1);
  localparam logic [13:0] BLOCK_LAST = 14'(BLOCK_CYCLES - 1);

  // Command decode
  logic is_param;     // Parameter write seen
  logic is_exchange;  // Data exchange seen
  logic is_delete;    // Delete address seen

  // Port control state
  logic           xchg_disable; // Exchange disable flag
  logic           drive_enable; // Output driving allowed
  logic [3:0]     out_reg;      // Output holding register
  sbio_state_type state;        // Output sequence state
  logic [8:0]     cnt;          // Cycles since output write
  logic           clear_run;    // Sequence is a reset strobe

  // Derived sequence events
  logic start_xchg; // Exchange accepted this cycle
  logic sample_now; // Input sampling edge
  logic hiz_window; // Multiplexed float window

  // Input path
  logic [3:0]  inv_mask;   // Effective inversion mask
  logic [3:0]  cond_in;    // Inverted inputs
  logic [3:0]  filt_out;   // Filter outputs
  logic [3:0]  selected;   // Value offered to the master
  logic        bypass;     // Pin one turns filters off
  logic        cycle_mode; // Cycle-based filtering
  logic [10:0] limit;      // Filter ticks for time code
  logic [8:0]  tick_cnt;   // Timebase divider
  logic        tick;       // Timebase tick
  logic [13:0] blk_cnt;    // Sampling block counter
  logic        blocked;    // Sampling blocked
  logic        cyc_evt;    // Cycle-mode sample event
  logic        answer_now; // Reply launch, one cycle after sampling

  // Command decode
  always_comb begin
    is_param    = CMD.valid && CMD.code == SBIO_CMD_PARAM;
    is_exchange = CMD.valid && CMD.code == SBIO_CMD_EXCHANGE;
    is_delete   = CMD.valid && CMD.code == SBIO_CMD_DELETE;
  end

  // Exchanges start only when idle and enabled
  // R10
  assign start_xchg = is_exchange && !xchg_disable // R8
                      && state == SBIO_ST_IDLE;

  // Sampling edge at the end of the wait
  assign sample_now = state == SBIO_ST_WAIT // R6
                      && cnt == SAMPLE_AT - 9'h001;

  // Float window spans setup and hold around the fall
  assign hiz_window = CFG.mux_data // R4
                      && (state == SBIO_ST_SETUP
                      || (state == SBIO_ST_STROBE && cnt < HIZ_END));

  // Exchange disable flag
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      xchg_disable <= 1'b1; // R8
    end else if (is_delete) begin
      xchg_disable <= 1'b1; // R8
    end else if (is_param) begin
      xchg_disable <= 1'b0; // R9
    end
  end

  // Output driving enable, first parameter event turns it on
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      drive_enable <= 1'b0; // R7
    end else if (is_delete) begin
      drive_enable <= 1'b0; // R7
    end else if (is_param) begin
      drive_enable <= 1'b1; // R22
    end
  end

  // Output holding register
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      out_reg <= `SBIO_OUT_RESET; // R7
    end else if (is_delete) begin
      out_reg <= `SBIO_OUT_RESET; // R7
    end else if (start_xchg) begin
      out_reg <= CMD.data; // R2
    end
  end

  // Output sequence; reset starts a strobe straight away
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      state     <= SBIO_ST_SETUP; // R7
      cnt       <= 9'h000;
      clear_run <= 1'b1;
    end else if (is_delete) begin
      // Delete aborts any running exchange
      state     <= SBIO_ST_SETUP; // R7
      cnt       <= 9'h000;
      clear_run <= 1'b1;
    end else begin
      case (state)
        SBIO_ST_IDLE: begin
          // Wait for an accepted exchange
          cnt <= 9'h000;
          if (start_xchg) begin
            state     <= SBIO_ST_SETUP;
            clear_run <= 1'b0;
          end
        end
        SBIO_ST_SETUP: begin
          // Data stands before the strobe falls
          cnt <= cnt + 9'h001;
          if (cnt == SETUP_END - 9'h001) begin
            state <= SBIO_ST_STROBE; // R3
          end
        end
        SBIO_ST_STROBE: begin
          // Strobe held low for its pulse width
          cnt <= cnt + 9'h001;
          if (cnt == STROBE_END - 9'h001) begin
            // Reset strobes carry no input sampling
            state <= clear_run ? SBIO_ST_IDLE : SBIO_ST_WAIT; // R5
          end
        end
        SBIO_ST_WAIT: begin
          // Inputs must settle before sampling
          cnt <= cnt + 9'h001;
          if (sample_now) begin
            state <= SBIO_ST_IDLE;
          end
        end
        default: begin
          state <= SBIO_ST_IDLE;
          cnt   <= 9'h000;
        end
      endcase
    end
  end

  // Strobe pin follows the state one cycle later
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      DATA_STROBE_N <= 1'b1;
    end else begin
      DATA_STROBE_N <= state != SBIO_ST_STROBE; // R5
    end
  end

  // Open-drain drivers pull low for zero bits only
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      DATA_OUT_PINS_O  <= 4'h0;
      DATA_OUT_PINS_OE <= 4'h0; // R7
    end else begin
      DATA_OUT_PINS_O <= 4'h0; // R1
      if (drive_enable && !hiz_window) begin
        DATA_OUT_PINS_OE <= ~out_reg; // R2
      end else begin
        // Floating keeps external pull-ups in charge
        DATA_OUT_PINS_OE <= 4'h0; // R4
      end
    end
  end

  // Output pin level read back for the user
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      DATA_OUT_READBACK <= 4'h0;
    end else begin
      DATA_OUT_READBACK <= DATA_OUT_PINS_I;
    end
  end

  // Inversion ahead of filtering
  always_comb begin
    if (CFG.invert_all) begin
      inv_mask = `SBIO_INV_ALL; // R11
    end else begin
      inv_mask = CFG.input_invert_mask; // R12
    end
    cond_in = DATA_IN_PINS ^ inv_mask; // R23
  end

  // Filter time selection
  always_comb begin
    cycle_mode = CFG.filter_time_code == `SBIO_CYCLE_CODE; // R14
    limit      = `SBIO_FILT_BASE_TICKS << CFG.filter_time_code; // R14
    bypass     = CFG.pin_filter_control_flag && PARAM_PIN_ONE; // R19
  end

  // Timebase; ticks of 8 us give the minus tolerance
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      tick_cnt <= 9'h000; // R18
      tick     <= 1'b0;
    end else begin
      tick     <= tick_cnt == TICK_LAST; // R23
      tick_cnt <= (tick_cnt == TICK_LAST) ? 9'h000 : tick_cnt + 9'h001;
    end
  end

  // Sampling block after each cycle-mode sample
  assign blocked = blk_cnt != 14'h0000;
  assign cyc_evt = sample_now && cycle_mode && !blocked; // R16

  // Master retries inside the block window see old data
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      blk_cnt <= 14'h0000;
    end else if (cyc_evt) begin
      blk_cnt <= BLOCK_LAST; // R16
    end else if (blocked) begin
      blk_cnt <= blk_cnt - 14'h0001;
    end
  end

  // One debounce filter per input channel
  for (genvar i = 0; i < 4; i++) begin : g_filt
    sbio_debounce u_filt (
      .clk        (SYS_CLK),
      .arst_n     (ARST_N),
      .raw        (cond_in[i]),
      .tick       (tick),
      .limit      (limit),
      .cycle_mode (cycle_mode),
      .sample_evt (cyc_evt),
      .filt       (filt_out[i])
    ); // R13
  end

  // Filtered or raw value per channel
  always_comb begin
    for (int j = 0; j < 4; j++) begin
      // Filters keep running even when bypassed
      if (CFG.input_filter_mask[j] && !bypass) begin
        selected[j] = filt_out[j]; // R17
      end else begin
        selected[j] = cond_in[j]; // R21
      end
    end
  end

  // Reply one cycle after sampling, so a cycle-mode filter
  // update made at the sampling edge is already in the answer
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      answer_now <= 1'b0;
    end else begin
      answer_now <= sample_now; // R15
    end
  end

  // Answer carries the sampled inputs
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      RESP <= '0;
    end else begin
      RESP.valid <= answer_now; // R6
      if (answer_now) begin
        RESP.data <= selected; // R6
      end
    end
  end

  // Status outputs
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      EXCHANGE_DISABLED    <= 1'b1;
      BUSY                 <= 1'b1;
      PARAM_PIN_ONE_MUX_EN <= 1'b0;
    end else begin
      EXCHANGE_DISABLED <= xchg_disable; // R8
      BUSY              <= state != SBIO_ST_IDLE;
      // Undriven pin one must not turn filters off
      PARAM_PIN_ONE_MUX_EN <= !(CFG.param_mux
                              && CFG.pin_filter_control_flag); // R20
    end
  end

endmodule : sbio_data_port

//--- test/sbio_field_model.sv
// Sensors and actuators hanging on the data pins
module sbio_field_model (
  // Open-drain pull-low enables from the block
  input  wire logic [3:0] oe,
  // Sensor levels chosen by the bench
  input  wire logic [3:0] sense,
  // Resolved pin levels
  output logic [3:0]      out_pins,
  output logic [3:0]      in_pins
);
  timeunit 1ns;
  timeprecision 100ps;
  // Pull-up resistor wins unless the block pulls low
  assign out_pins = ~oe;
  // Sensors hold steady across each sampling window
  assign in_pins = sense;
endmodule : sbio_field_model

//--- test/sbio_data_port_props.sv
module sbio_data_port_props
  import sbio_pkg::*;
#(
  parameter int unsigned BLOCK_CYCLES = 64
) (
  // Clock and reset
  input wire logic          SYS_CLK,
  input wire logic          ARST_N,
  // Watched inputs
  input wire sbio_cmd_type  CMD,
  input wire sbio_cfg_type  CFG,
  // Watched outputs
  input wire logic [3:0]    DATA_OUT_PINS_O,
  input wire logic [3:0]    DATA_OUT_PINS_OE,
  input wire logic          DATA_STROBE_N,
  input wire sbio_resp_type RESP,
  input wire logic          EXCHANGE_DISABLED,
  input wire logic          BUSY,
  input wire logic          PARAM_PIN_ONE_MUX_EN
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!ARST_N);
  // Causes seen at the command and configuration ports
  logic       acc;
  logic       del;
  logic       prm;
  logic       mxl;
  // Data of the last accepted exchange
  logic [3:0] d_q;
  // Cycles the strobe has been low
  logic [8:0] low_cnt;
  // BUSY lags a cycle, so a second request right away is still counted
  assign acc = CMD.valid && CMD.code == SBIO_CMD_EXCHANGE && !EXCHANGE_DISABLED && !BUSY;
  assign del = CMD.valid && CMD.code == SBIO_CMD_DELETE;
  assign prm = CMD.valid && CMD.code == SBIO_CMD_PARAM;
  assign mxl = CFG.param_mux & CFG.pin_filter_control_flag;
  // Capture exchange data
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      d_q <= 4'h0;
    end else if (acc) begin
      d_q <= CMD.data;
    end
  end
  // Strobe width counter
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      low_cnt <= 9'h000;
    end else begin
      low_cnt <= DATA_STROBE_N ? 9'h000 : low_cnt + 9'h001;
    end
  end
  property p_od;
    DATA_OUT_PINS_O == 4'h0;
  endproperty
  // Checks land two cycles in so either edge reading of the walk holds
  property p_xchg;
    acc && !CFG.mux_data |-> ##2 (DATA_OUT_PINS_OE == ~d_q) ##18 DATA_STROBE_N
      ##2 !DATA_STROBE_N;
  endproperty
  property p_mux;
    acc && CFG.mux_data |-> ##2 (DATA_OUT_PINS_OE == 4'h0) [*8] ##31
      (DATA_OUT_PINS_OE == 4'h0) ##2 (DATA_OUT_PINS_OE == ~d_q);
  endproperty
  property p_wid;
    $rose(DATA_STROBE_N) |-> low_cnt == 9'h0DC;
  endproperty
  property p_ans;
    RESP.valid |-> $past(acc, 482);
  endproperty
  property p_del;
    del |-> ##2 (EXCHANGE_DISABLED && DATA_OUT_PINS_OE == 4'h0) ##18 DATA_STROBE_N
      ##2 !DATA_STROBE_N;
  endproperty
  property p_dis;
    EXCHANGE_DISABLED |-> !RESP.valid;
  endproperty
  property p_prm;
    prm |-> ##2 !EXCHANGE_DISABLED;
  endproperty
  property p_mxl;
    $past(ARST_N) |-> PARAM_PIN_ONE_MUX_EN == !$past(mxl);
  endproperty
  a_od: assert property (p_od) else $error("data pin driven high");
  a_xchg: assert property (p_xchg) else $error("output or strobe timing off");
  a_mux: assert property (p_mux) else $error("float window wrong");
  a_wid: assert property (p_wid) else $error("strobe width wrong");
  a_ans: assert property (p_ans) else $error("answer at wrong time");
  a_del: assert property (p_del) else $error("delete sequence wrong");
  a_dis: assert property (p_dis) else $error("answer while disabled");
  a_prm: assert property (p_prm) else $error("param left port disabled");
  a_mxl: assert property (p_mxl) else $error("pin one mux enable wrong");
  // Main scenarios reached
  c_ans: cover property (RESP.valid);
  c_del: cover property (del);
  c_mux: cover property (acc && CFG.mux_data);
endmodule : sbio_data_port_props

bind sbio_data_port sbio_data_port_props #(.BLOCK_CYCLES(BLOCK_CYCLES)) chk_u (
  .SYS_CLK(SYS_CLK), .ARST_N(ARST_N), .CMD(CMD), .CFG(CFG),
  .DATA_OUT_PINS_O(DATA_OUT_PINS_O), .DATA_OUT_PINS_OE(DATA_OUT_PINS_OE),
  .DATA_STROBE_N(DATA_STROBE_N), .RESP(RESP), .EXCHANGE_DISABLED(EXCHANGE_DISABLED),
  .BUSY(BUSY), .PARAM_PIN_ONE_MUX_EN(PARAM_PIN_ONE_MUX_EN));

//--- test/slave_binary_io_data_port_bench.sv
module slave_binary_io_data_port_bench
  import sbio_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  // Clock, reset and stimulus
  logic          clk = 1'b0;
  logic          rst_n = 1'b0;
  sbio_cmd_type  cmd = '0;
  sbio_cfg_type  cfg = '0;
  logic          pin_one = 1'b0;
  logic [3:0]    sense = 4'h0;
  // Pins and status
  logic [3:0]    in_pins;
  logic [3:0]    out_lvl;
  logic [3:0]    oe;
  logic [3:0]    rb;
  logic          strb_n;
  logic          dis;
  logic          busy;
  logic          mux_en;
  logic          saw_low = 1'b0;
  sbio_resp_type resp;
  // Score
  int            bad_count = 0;
  int            n_tests = 0;

  // 40 MHz clock
  always #12.5 clk = ~clk;

  // Field devices on the pins
  sbio_field_model field_u (.oe(oe), .sense(sense), .out_pins(out_lvl), .in_pins(in_pins));

  // Sampling block shortened but kept above one exchange period
  sbio_data_port #(.BLOCK_CYCLES(600)) dut_u (
    .SYS_CLK(clk), .ARST_N(rst_n), .CMD(cmd), .CFG(cfg), .PARAM_PIN_ONE(pin_one),
    .DATA_IN_PINS(in_pins), .DATA_OUT_PINS_I(out_lvl), .DATA_OUT_PINS_O(),
    .DATA_OUT_PINS_OE(oe), .DATA_STROBE_N(strb_n), .RESP(resp),
    .EXCHANGE_DISABLED(dis), .BUSY(busy), .PARAM_PIN_ONE_MUX_EN(mux_en),
    .DATA_OUT_READBACK(rb));

  // Remember any strobe pulse
  always @(negedge clk) begin
    if (strb_n === 1'b0) saw_low = 1'b1;
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : tally_and_finish

  task automatic hang();
    bad_count++;
    $display("[ERR] %0t wait ran out", $time);
    tally_and_finish();
  endtask : hang

  task automatic chk(input logic [3:0] got, input logic [3:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask : chk

  // One command, valid for a single edge
  task automatic cmd_go(input sbio_cmd_code_type c, input logic [3:0] d);
    @(negedge clk);
    cmd = '{valid: 1'b1, code: c, data: d};
    @(negedge clk);
    cmd = '0;
  endtask : cmd_go

  // Look for an answer, then let the sequence go idle
  task automatic wait_ans(input logic want, input logic [3:0] exp);
    logic got;
    got = 1'b0;
    for (int i = 0; i < 600 && !got; i++) begin
      @(negedge clk);
      got = (resp.valid === 1'b1);
    end
    if (want && !got) hang();
    chk({3'h0, got}, {3'h0, want});
    if (got) chk(resp.data, exp);
    for (int i = 0; i < 300 && busy !== 1'b0; i++) @(negedge clk);
    if (busy !== 1'b0) hang();
  endtask : wait_ans

  task automatic xchg(input logic [3:0] d, input logic want, input logic [3:0] exp);
    cmd_go(SBIO_CMD_EXCHANGE, d);
    wait_ans(want, exp);
  endtask : xchg

  task automatic do_reset();
    rst_n = 1'b0;
    saw_low = 1'b0;
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    for (int i = 0; i < 300 && busy !== 1'b0; i++) @(negedge clk);
    if (busy !== 1'b0) hang();
    chk({3'h0, saw_low}, 4'h1);
    chk({3'h0, dis}, 4'h1);
    chk(oe, 4'h0);
  endtask : do_reset

  task automatic t_boot();
    xchg(4'h5, 1'b0, 4'h0);
    cmd_go(SBIO_CMD_PARAM, 4'h0);
    @(negedge clk);
    chk({3'h0, dis}, 4'h0);
    chk(oe, 4'h0);
    chk({3'h0, mux_en}, 4'h1);
    $display("t_boot done");
  endtask : t_boot

  task automatic t_out();
    sense = 4'h9;
    xchg(4'h5, 1'b1, 4'h9);
    chk(oe, 4'hA);
    chk(rb, 4'h5);
    // Request C, sent while request 3 is still busy, must be dropped
    cmd_go(SBIO_CMD_EXCHANGE, 4'h3);
    xchg(4'hC, 1'b1, 4'h9);
    chk(oe, 4'hC);
    $display("t_out done");
  endtask : t_out

  task automatic t_inv();
    sense = 4'hA;
    cfg.invert_all = 1'b1;
    xchg(4'h0, 1'b1, 4'h5);
    cfg.input_invert_mask = 4'h3;
    xchg(4'h0, 1'b1, 4'h5);
    cfg.invert_all = 1'b0;
    xchg(4'h0, 1'b1, 4'h9);
    cfg.input_invert_mask = 4'h0;
    $display("t_inv done");
  endtask : t_inv

  // Code 0: pass between 4800 and 5120 cycles of stable level
  task automatic t_filt();
    sense = 4'h0;
    cfg.input_filter_mask = 4'h1;
    repeat (6000) @(negedge clk);
    sense = 4'hF;
    repeat (4200) @(negedge clk);
    xchg(4'h0, 1'b1, 4'hE);
    repeat (1000) @(negedge clk);
    xchg(4'h0, 1'b1, 4'hF);
    cfg.pin_filter_control_flag = 1'b1;
    cfg.param_mux = 1'b1;
    pin_one = 1'b1;
    sense = 4'h0;
    xchg(4'h0, 1'b1, 4'h0);
    chk({3'h0, mux_en}, 4'h0);
    pin_one = 1'b0;
    xchg(4'h0, 1'b1, 4'h1);
    cfg.pin_filter_control_flag = 1'b0;
    cfg.param_mux = 1'b0;
    // Code 1 doubles the wait: pass between 9920 and 10240 cycles
    cfg.filter_time_code = 3'h1;
    sense = 4'hF;
    @(negedge clk);
    sense = 4'h0;
    repeat (9300) @(negedge clk);
    xchg(4'h0, 1'b1, 4'h1);
    repeat (500) @(negedge clk);
    xchg(4'h0, 1'b1, 4'h0);
    cfg.filter_time_code = 3'h0;
    $display("t_filt done");
  endtask : t_filt

  // Cycle mode after a second reset; middle sample falls in the block
  task automatic t_cycle();
    cfg.filter_time_code = 3'h7;
    cfg.input_filter_mask = 4'hF;
    sense = 4'hF;
    do_reset();
    cmd_go(SBIO_CMD_PARAM, 4'h0);
    xchg(4'h0, 1'b1, 4'h0);
    xchg(4'h0, 1'b1, 4'h0);
    repeat (200) @(negedge clk);
    xchg(4'h0, 1'b1, 4'hF);
    cfg.input_filter_mask = 4'h0;
    cfg.filter_time_code = 3'h0;
    $display("t_cycle done");
  endtask : t_cycle

  task automatic t_mux();
    cfg.mux_data = 1'b1;
    sense = 4'h3;
    cmd_go(SBIO_CMD_EXCHANGE, 4'h6);
    repeat (10) @(negedge clk);
    chk(oe, 4'h0);
    wait_ans(1'b1, 4'h3);
    chk(oe, 4'h9);
    cfg.mux_data = 1'b0;
    $display("t_mux done");
  endtask : t_mux

  // Delete after the strobe aborts the answer
  task automatic t_del();
    cmd_go(SBIO_CMD_EXCHANGE, 4'h0);
    repeat (300) @(negedge clk);
    saw_low = 1'b0;
    cmd_go(SBIO_CMD_DELETE, 4'h0);
    @(negedge clk);
    chk({3'h0, dis}, 4'h1);
    chk(oe, 4'h0);
    wait_ans(1'b0, 4'h0);
    chk({3'h0, saw_low}, 4'h1);
    xchg(4'h0, 1'b0, 4'h0);
    $display("t_del done");
  endtask : t_del

  // Main sequence
  initial begin
    do_reset();
    t_boot();
    t_out();
    t_inv();
    t_filt();
    t_cycle();
    t_mux();
    t_del();
    tally_and_finish();
  end
endmodule : slave_binary_io_data_port_bench
